/* hw/thmo_multi_op.sv */
// Purpose: multi-operator combiner of operator and release inputs
// Assumes: tick is a one-cycle pulse per evaluation step
// Notes:   run low holds the combiner in its stop state
`timescale 1ns/1ps
module thmo_multi_op (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [2:0] op,
    input  wire logic       ops3,
    input  wire logic [1:0] rel_in,
    input  wire logic [1:0] n_rel,
    input  wire logic       cyc_req,
    input  wire logic       cyc_fall,
    output logic            release_r,
    output logic [2:0]      let_go_r
);
    logic [2:0] op_en;
    logic [1:0] rel_en;
    logic       rel_ok;
    logic       ops_ok;
    logic       cyc_edge;
    logic       cyc_prev_r;
    logic       waive_r;
    assign op_en    = {ops3, 2'b11};
    assign rel_en   = {n_rel[1], n_rel[1] | n_rel[0]};
    assign rel_ok   = &(rel_in | ~rel_en);
    assign ops_ok   = &(op | ~op_en);
    assign cyc_edge = cyc_fall ? (cyc_prev_r & ~cyc_req) : (~cyc_prev_r & cyc_req);
    // release output and let-go bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            release_r  <= 1'b0;
            let_go_r   <= 3'h0;
            waive_r    <= 1'b1;
            cyc_prev_r <= 1'b0;
        end else if (tick) begin
            cyc_prev_r <= cyc_req;
            if (!run) begin
                release_r <= 1'b0;
                let_go_r  <= 3'h0;
                waive_r   <= 1'b1;
            end else if (!rel_ok || !ops_ok || cyc_edge) begin
                release_r <= 1'b0;
                let_go_r  <= let_go_r | (~op & op_en);
                if (!rel_ok || cyc_edge) waive_r <= 1'b1;
            end else if (!release_r && (waive_r || &(let_go_r | ~op_en))) begin
                release_r <= 1'b1;
                let_go_r  <= 3'h0;
                waive_r   <= 1'b0;
            end
        end
    end
endmodule

/* hw/thmo_pair.sv */
// Purpose: one complementary dual-channel pair with discrepancy timer
// Assumes: tick is a one-cycle pulse per 10 ms step
// Notes:   steps of zero disable the timeout
`timescale 1ns/1ps
module thmo_pair import thmo_pkg::*; (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          tick,
    input  wire thmo_pair_in_t pin,
    input  wire logic [5:0]    steps,
    output thmo_pair_st_t      st_r,
    output logic               err_r
);
    logic [5:0] cnt_r;
    logic       seen_off_r;
    logic       expired;
    assign expired = (steps != 6'h00) && (cnt_r >= steps);
    // pair state, evaluated once per step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r       <= PAIR_DISC;
            err_r      <= 1'b0;
            cnt_r      <= 6'h00;
            seen_off_r <= 1'b0;
        end else if (tick) begin
            if (!pin.a && pin.b) begin
                st_r       <= PAIR_DIS;
                seen_off_r <= 1'b1;
                cnt_r      <= 6'h00;
            end else if (pin.a && !pin.b) begin
                if (st_r == PAIR_ACT || (seen_off_r && !expired)) begin
                    st_r       <= PAIR_ACT;
                    err_r      <= 1'b0; // cleared by good activation
                    seen_off_r <= 1'b0;
                end else begin
                    st_r <= PAIR_DISC;
                end
            end else begin
                st_r <= PAIR_DISC;
                if (cnt_r != 6'h3f) cnt_r <= cnt_r + 6'h01;
                if ((steps != 6'h00) && (cnt_r + 6'h01 >= steps)) err_r <= 1'b1;
            end
        end
    end
endmodule

/* hw/thmo_params.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz aclk, 10 ms evaluation step
// Notes:   included by the top module only, the package does not include it
`ifndef THMO_PARAMS_SVH
`define THMO_PARAMS_SVH
`define THMO_CLK_MHZ     100
`define THMO_STEP_MS     10
`define THMO_STEP_CYCLES (`THMO_STEP_MS * 1000 * `THMO_CLK_MHZ)
`define THMO_MAX_MS      500
`define THMO_MAX_STEPS   6'h32
`define THMO_OFS_DISC    4'h0
`define THMO_OFS_SYNC    4'h4
`define THMO_OFS_CFG     4'h8
`define THMO_OFS_STAT    4'hc
`define THMO_DISC2_LSB   8
`define THMO_CFG_NOUT    0
`define THMO_CFG_FAULT   2
`define THMO_CFG_CYCF    3
`define THMO_CFG_OPS3    4
`define THMO_CFG_NREL    5
`define THMO_DISC_RST    32'h0000_0000
`define THMO_SYNC_RST    32'h0000_0000
`define THMO_CFG_RST     32'h0000_0001
`endif

/* hw/thmo_pkg.sv */
// Purpose: shared types of the two-hand / multi-operator block
// Assumes: nothing
// Notes:   constants live in thmo_params.svh
package thmo_pkg;
    typedef enum logic [1:0] {
        PAIR_DIS  = 2'b00,
        PAIR_DISC = 2'b01,
        PAIR_ACT  = 2'b10
    } thmo_pair_st_t;
    typedef enum logic [1:0] {
        EV_DIS  = 2'b00,
        EV_SYNC = 2'b01,
        EV_EN   = 2'b10,
        EV_LOCK = 2'b11
    } thmo_ev_st_t;
    typedef struct packed {
        logic a;
        logic b;
    } thmo_pair_in_t;
    typedef struct packed {
        logic [5:0] disc1;
        logic [5:0] disc2;
        logic [5:0] sync;
        logic [1:0] n_out;
        logic       use_fault;
        logic       cyc_fall;
        logic       ops3;
        logic [1:0] n_rel;
    } thmo_cfg_t;
endpackage

/* hw/thmo_top.sv */
// Purpose: two-hand evaluator plus multi-operator combiner with AXI4-Lite
// Assumes: inputs synchronous to aclk, one evaluation step per 10 ms
// Notes:   operator 1 is the local evaluator, operators 2 and 3 are pins
`timescale 1ns/1ps
`include "thmo_params.svh"

module thmo_top import thmo_pkg::*; #(
    parameter int STEP_CYCLES = `THMO_STEP_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hand_one_chan_a,
    input  wire logic        hand_one_chan_b,
    input  wire logic        hand_two_chan_a,
    input  wire logic        hand_two_chan_b,
    input  wire logic        run_mode,
    input  wire logic [1:0]  op_ext,
    input  wire logic [1:0]  rel_in,
    input  wire logic        cyc_req,
    output logic             enable_r,
    output logic             disc_err_one_r,
    output logic             disc_err_two_r,
    output logic             fault_present_r,
    output logic             release_o
);
    localparam int TW = $clog2(STEP_CYCLES + 1);

    //--------------------------------------------------------------
    // registers and step timer
    //--------------------------------------------------------------
    logic [31:0]   disc_reg_r;
    logic [31:0]   sync_reg_r;
    logic [31:0]   cfg_reg_r;
    thmo_cfg_t     cfg;
    logic [TW-1:0] step_cnt_r;
    logic          tick;
    logic [5:0]    sync_steps;
    logic [5:0]    disc1_steps;
    logic [5:0]    disc2_steps;

    // one tick per logic execution step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_cnt_r <= '0;
        end else if (step_cnt_r == TW'(STEP_CYCLES - 1)) begin
            step_cnt_r <= '0;
        end else begin
            step_cnt_r <= step_cnt_r + TW'(1);
        end
    end
    assign tick = (step_cnt_r == TW'(STEP_CYCLES - 1));

    // unpack register fields
    assign cfg.disc1     = disc_reg_r[5:0];
    assign cfg.disc2     = disc_reg_r[`THMO_DISC2_LSB +: 6];
    assign cfg.sync      = sync_reg_r[5:0];
    assign cfg.n_out     = cfg_reg_r[`THMO_CFG_NOUT +: 2];
    assign cfg.use_fault = cfg_reg_r[`THMO_CFG_FAULT];
    assign cfg.cyc_fall  = cfg_reg_r[`THMO_CFG_CYCF];
    assign cfg.ops3      = cfg_reg_r[`THMO_CFG_OPS3];
    assign cfg.n_rel     = cfg_reg_r[`THMO_CFG_NREL +: 2];

    // clamp times to 500 ms, sync zero behaves as 500 ms
    assign disc1_steps = (cfg.disc1 > `THMO_MAX_STEPS) ? `THMO_MAX_STEPS : cfg.disc1;
    assign disc2_steps = (cfg.disc2 > `THMO_MAX_STEPS) ? `THMO_MAX_STEPS : cfg.disc2;
    assign sync_steps  = (cfg.sync == 6'h00 || cfg.sync > `THMO_MAX_STEPS)
                         ? `THMO_MAX_STEPS : cfg.sync;

    //--------------------------------------------------------------
    // input pairs
    //--------------------------------------------------------------
    thmo_pair_st_t p1_st;
    thmo_pair_st_t p2_st;
    logic          p1_err;
    logic          p2_err;

    thmo_pair u_pair_one (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .pin     ('{a: hand_one_chan_a, b: hand_one_chan_b}),
        .steps   (disc1_steps),
        .st_r    (p1_st),
        .err_r   (p1_err)
    );

    thmo_pair u_pair_two (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .pin     ('{a: hand_two_chan_a, b: hand_two_chan_b}),
        .steps   (disc2_steps),
        .st_r    (p2_st),
        .err_r   (p2_err)
    );

    //--------------------------------------------------------------
    // synchronization state machine
    //--------------------------------------------------------------
    thmo_ev_st_t ev_st_r;
    logic [5:0]  sync_cnt_r;
    logic        both_dis;
    logic        both_act;

    assign both_dis = (p1_st == PAIR_DIS) && (p2_st == PAIR_DIS);
    assign both_act = (p1_st == PAIR_ACT) && (p2_st == PAIR_ACT);

    // disabled -> sync window -> enabled, lock until both released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_st_r    <= EV_LOCK;
            sync_cnt_r <= 6'h00;
        end else if (tick) begin
            case (ev_st_r)
                EV_DIS: begin
                    sync_cnt_r <= 6'h00;
                    if (both_act) begin
                        ev_st_r <= EV_EN;
                    end else if (!both_dis) begin
                        ev_st_r <= EV_SYNC;
                    end
                end
                EV_SYNC: begin
                    if (both_act) begin
                        ev_st_r <= EV_EN;
                    end else if (both_dis) begin
                        ev_st_r <= EV_DIS;
                    end else if (sync_cnt_r + 6'h01 >= sync_steps) begin
                        ev_st_r <= EV_LOCK;
                    end else begin
                        sync_cnt_r <= sync_cnt_r + 6'h01;
                    end
                end
                EV_EN: begin
                    if (!both_act) ev_st_r <= EV_LOCK;
                end
                default: begin
                    if (both_dis) ev_st_r <= EV_DIS;
                end
            endcase
        end
    end

    // evaluator outputs, discrepancy errors gated by output count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r        <= 1'b0;
            disc_err_one_r  <= 1'b0;
            disc_err_two_r  <= 1'b0;
            fault_present_r <= 1'b0;
        end else begin
            enable_r        <= (ev_st_r == EV_EN) && both_act;
            disc_err_one_r  <= p1_err && (cfg.n_out >= 2'h2);
            disc_err_two_r  <= p2_err && (cfg.n_out == 2'h3);
            fault_present_r <= cfg.use_fault && (p1_err || p2_err);
        end
    end

    //--------------------------------------------------------------
    // multi-operator combiner
    //--------------------------------------------------------------
    logic [2:0] let_go;

    thmo_multi_op u_multi_op (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (tick),
        .run       (run_mode),
        .op        ({op_ext, enable_r}),
        .ops3      (cfg.ops3),
        .rel_in    (rel_in),
        .n_rel     (cfg.n_rel),
        .cyc_req   (cyc_req),
        .cyc_fall  (cfg.cyc_fall),
        .release_r (release_o),
        .let_go_r  (let_go)
    );

    //--------------------------------------------------------------
    // AXI4-Lite slave
    //--------------------------------------------------------------
    logic        aw_hold_r;
    logic [3:0]  aw_addr_r;
    logic        w_hold_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        do_wr;
    logic [31:0] rd_mux;
    logic        rd_hit;

    // merge write data under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
        end
        return res;
    endfunction

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr         = aw_hold_r && w_hold_r;

    // capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_hold_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (do_wr) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disc_reg_r   <= `THMO_DISC_RST;
            sync_reg_r   <= `THMO_SYNC_RST;
            cfg_reg_r    <= `THMO_CFG_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                if (aw_addr_r[3:2] == `THMO_OFS_DISC >> 2) begin
                    disc_reg_r <= merge(disc_reg_r, w_data_r, w_strb_r) & 32'h0000_3f3f;
                end else if (aw_addr_r[3:2] == `THMO_OFS_SYNC >> 2) begin
                    sync_reg_r <= merge(sync_reg_r, w_data_r, w_strb_r) & 32'h0000_003f;
                end else if (aw_addr_r[3:2] == `THMO_OFS_CFG >> 2) begin
                    cfg_reg_r <= merge(cfg_reg_r, w_data_r, w_strb_r) & 32'h0000_007f;
                end else begin
                    s_axi_bresp <= 2'h2; // status is read-only
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr[3:2] == `THMO_OFS_DISC >> 2) begin
            rd_mux = disc_reg_r;
        end else if (s_axi_araddr[3:2] == `THMO_OFS_SYNC >> 2) begin
            rd_mux = sync_reg_r;
        end else if (s_axi_araddr[3:2] == `THMO_OFS_CFG >> 2) begin
            rd_mux = cfg_reg_r;
        end else if (s_axi_araddr[3:2] == `THMO_OFS_STAT >> 2) begin
            rd_mux = {20'h0_0000, let_go, ev_st_r, p2_err, p1_err,
                      release_o, fault_present_r, enable_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read response one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* test/thmo_hands.sv */
// Purpose: behavioural model of the two hand switches
// Assumes: press and stuck change just after a rising edge
// Notes:   a stuck hand also holds its B contact closed
`timescale 1ns/1ps
module thmo_hands (
    input  wire logic       aclk,
    input  wire logic [1:0] press,
    input  wire logic [1:0] stuck,
    output logic            hand_one_chan_a,
    output logic            hand_one_chan_b,
    output logic            hand_two_chan_a,
    output logic            hand_two_chan_b
);
    // ----------------
    // contact outputs
    // ----------------
    // A follows the hand, B is its complement unless the contact sticks
    always_ff @(posedge aclk) begin
        hand_one_chan_a <= press[0];
        hand_one_chan_b <= ~press[0] | stuck[0];
        hand_two_chan_a <= press[1];
        hand_two_chan_b <= ~press[1] | stuck[1];
    end
endmodule

/* test/thmo_top_assertions.sv */
// Purpose: port-level timing checks of thmo_top
// Assumes: one evaluation step is STEP_CYCLES cycles
// Notes:   lag counters count cycles since a pin pattern last held
`timescale 1ns/1ps
module thmo_top_assertions #(
    parameter int STEP_CYCLES = 8
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        hand_one_chan_a,
    input wire logic        hand_one_chan_b,
    input wire logic        hand_two_chan_a,
    input wire logic        hand_two_chan_b,
    input wire logic        run_mode,
    input wire logic [1:0]  op_ext,
    input wire logic        enable_r,
    input wire logic        disc_err_one_r,
    input wire logic        disc_err_two_r,
    input wire logic        fault_present_r,
    input wire logic        release_o
);
    localparam int EN_LAG   = STEP_CYCLES + 1;
    localparam int DROP_LAG = 2 * STEP_CYCLES + 2;
    localparam int SYNC_LAG = 54 * STEP_CYCLES;
    localparam int REL_LAG  = STEP_CYCLES + 2;
    logic        all_act;
    logic        all_rel;
    logic [15:0] idle_c;
    logic [15:0] rel_c;
    logic [15:0] d1_c;
    logic [15:0] lo_c;

    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // ----------------
    // lag counters
    // ----------------
    assign all_act = hand_one_chan_a & ~hand_one_chan_b & hand_two_chan_a & ~hand_two_chan_b;
    assign all_rel = ~hand_one_chan_a & hand_one_chan_b & ~hand_two_chan_a & hand_two_chan_b;
    // cycles since both hands pressed, both let go, pair one discrepant
    always_ff @(posedge aclk) idle_c <= (!aresetn || all_act) ? 16'h0000 : inc(idle_c);
    always_ff @(posedge aclk) rel_c <= (!aresetn || all_rel) ? 16'h0000 : inc(rel_c);
    always_ff @(posedge aclk) d1_c <= (!aresetn || hand_one_chan_a == hand_one_chan_b) ? 16'h0000 : inc(d1_c);
    // cycles with operator 1 or 2 or run low
    always_ff @(posedge aclk) lo_c <= (!aresetn || (enable_r && op_ext[0] && run_mode)) ? 16'h0000 : inc(lo_c);

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    property p_rst_clear;
        disable iff (1'b0) !aresetn |=> !enable_r && !release_o && !fault_present_r && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_en_rise;
        $rose(enable_r) |-> idle_c <= EN_LAG;
    endproperty
    property p_en_drop;
        idle_c > DROP_LAG |-> !enable_r;
    endproperty
    property p_en_sync;
        $rose(enable_r) |-> rel_c <= SYNC_LAG;
    endproperty
    property p_en_clean;
        $rose(enable_r) |-> !disc_err_one_r && !disc_err_two_r && !fault_present_r;
    endproperty
    property p_err_one;
        $rose(disc_err_one_r) |-> d1_c <= EN_LAG;
    endproperty
    property p_rel_rise;
        $rose(release_o) |-> $past(enable_r) && $past(op_ext[0]) && $past(run_mode);
    endproperty
    property p_rel_low;
        lo_c > REL_LAG |-> !release_o;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
    a_rd_hold: assert property (p_rd_hold) else $error("read answer not held");
    a_en_rise: assert property (p_en_rise) else $error("enable rose without both hands");
    a_en_drop: assert property (p_en_drop) else $error("enable held after a hand left");
    a_en_sync: assert property (p_en_sync) else $error("enable rose long after release");
    a_en_clean: assert property (p_en_clean) else $error("enable rose with an error");
    a_err_one: assert property (p_err_one) else $error("pair one error without discrepancy");
    a_rel_rise: assert property (p_rel_rise) else $error("release rose with an input low");
    a_rel_low: assert property (p_rel_low) else $error("release held with an input low");
endmodule

bind thmo_top thmo_top_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.*);

/* test/thmo_top_tb.sv */
// Purpose: self-checking bench of thmo_top
// Assumes: short evaluation step through STEP_CYCLES
// Notes:   hands come from thmo_hands, registers over AXI4-Lite
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module thmo_top_tb;
    localparam int SC    = 8;
    localparam int LIMIT = 20000;
    logic        aclk, aresetn, run_mode, cyc_req, saw_low;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        hand_one_chan_a, hand_one_chan_b, hand_two_chan_a, hand_two_chan_b;
    logic        enable_r, disc_err_one_r, disc_err_two_r, fault_present_r, release_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, op_ext, rel_in, press, stuck;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          mismatches, compares, cycles;

    thmo_top #(.STEP_CYCLES(SC)) u_dut (.*);
    thmo_hands u_hands (.*);

    // ----------------
    // clock, watchdog, closing
    // ----------------
    always #5 aclk = ~aclk;
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end
    // release low seen
    always @(negedge aclk) if (release_o === 1'b0) saw_low <= 1'b1;

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------
    // bus and stimulus tasks
    // ----------------
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK(s_axi_bresp, e)
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK(s_axi_rdata & m, e)
        s_axi_rready <= 1'b0;
    endtask

    task automatic steps(input int n);
        repeat (n * SC) @(posedge aclk);
    endtask

    task automatic hands(input logic [1:0] p, input logic [1:0] s, input int n);
        press <= p;
        stuck <= s;
        steps(n);
    endtask

    task automatic cyc(input logic v, input logic e);
        saw_low <= 1'b0;
        cyc_req <= v;
        steps(3);
        `CHK(saw_low, e)
    endtask

    // ----------------
    // test sequence
    // ----------------
    initial begin
        aclk = 1'b0;
        {aresetn, run_mode, cyc_req, saw_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, op_ext, rel_in, press, stuck, s_axi_awaddr} = '0;
        {s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
        repeat (5) @(posedge aclk);
        aresetn  <= 1'b1;
        run_mode <= 1'b1;
        rd(4'h0, 32'hffff_ffff, 32'h0000_0000);
        rd(4'h8, 32'hffff_ffff, 32'h0000_0001);
        wr(4'hc, 32'hffff_ffff, 4'hf, 2'b10);
        wr(4'h0, 32'h0000_0302, 4'h1, 2'b00);
        rd(4'h0, 32'hffff_ffff, 32'h0000_0002);
        wr(4'h0, 32'h0000_0303, 4'hf, 2'b00);
        wr(4'h4, 32'h0000_0004, 4'hf, 2'b00);
        wr(4'h8, 32'h0000_0027, 4'hf, 2'b00);
        $display("test registers finished");
        op_ext <= 2'b01;
        rel_in <= 2'b01;
        hands(2'b11, 2'b00, 3);
        `CHK(enable_r, 1'b1)
        steps(2);
        `CHK(release_o, 1'b1)
        rd(4'hc, 32'h0000_007f, 32'h0000_0045);
        rel_in <= 2'b00;
        steps(2);
        `CHK(release_o, 1'b0)
        rel_in <= 2'b01;
        steps(2);
        `CHK(release_o, 1'b1)
        op_ext <= 2'b00;
        steps(2);
        `CHK(release_o, 1'b0)
        op_ext <= 2'b01;
        steps(3);
        `CHK(release_o, 1'b0)
        hands(2'b00, 2'b00, 3);
        `CHK(enable_r, 1'b0)
        hands(2'b11, 2'b00, 4);
        `CHK(release_o, 1'b1)
        $display("test combiner finished");
        cyc(1'b1, 1'b1);
        `CHK(release_o, 1'b1)
        cyc(1'b0, 1'b0);
        wr(4'h8, 32'h0000_002f, 4'hf, 2'b00);
        cyc(1'b1, 1'b0);
        cyc(1'b0, 1'b1);
        run_mode <= 1'b0;
        steps(2);
        `CHK(release_o, 1'b0)
        run_mode <= 1'b1;
        steps(2);
        `CHK(release_o, 1'b1)
        $display("test cycle request finished");
        hands(2'b00, 2'b00, 3);
        hands(2'b01, 2'b00, 8);
        hands(2'b11, 2'b00, 4);
        `CHK(enable_r, 1'b0)
        `CHK(fault_present_r, 1'b0)
        hands(2'b00, 2'b00, 3);
        hands(2'b11, 2'b00, 3);
        `CHK(enable_r, 1'b1)
        wr(4'h4, 32'h0000_0000, 4'hf, 2'b00);
        hands(2'b00, 2'b00, 3);
        hands(2'b01, 2'b00, 40);
        hands(2'b11, 2'b00, 3);
        `CHK(enable_r, 1'b1)
        $display("test synchronization finished");
        hands(2'b00, 2'b00, 3);
        hands(2'b01, 2'b01, 5);
        `CHK(disc_err_one_r, 1'b1)
        `CHK(fault_present_r, 1'b1)
        hands(2'b11, 2'b11, 5);
        `CHK(disc_err_two_r, 1'b1)
        hands(2'b00, 2'b00, 3);
        hands(2'b11, 2'b00, 3);
        `CHK({enable_r, disc_err_one_r, disc_err_two_r, fault_present_r}, 4'h8)
        wr(4'h0, 32'h0000_0003, 4'hf, 2'b00);
        hands(2'b00, 2'b00, 3);
        hands(2'b10, 2'b10, 8);
        `CHK({disc_err_two_r, fault_present_r}, 2'b00)
        wr(4'h8, 32'h0000_0025, 4'hf, 2'b00);
        hands(2'b01, 2'b01, 5);
        `CHK({disc_err_one_r, fault_present_r}, 2'b01)
        $display("test discrepancy finished");
        finish_test();
    end
endmodule
